// [logic/sem_host.sv]
// Function
// - pollers drop select or oe between reads.
// - claim by writing zero, then reading back; zero means owned.
// - after a failed claim, keep reading or write one to withdraw.
// - software writes one to every latch from both sides at power-up; CMD_INIT writes one to all 8 flags from this side only.
`timescale 1ns/1ps
`default_nettype none
module sem_host #(
  parameter int ACCESS_CYCLES = sem_host_pkg::ACCESS_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire sem_host_pkg::req_t req,
  output logic done,
  output logic granted,
  output logic init_done,
  output var sem_host_pkg::pins_t pins,
  input wire logic [sem_host_pkg::DATA_W-1:0] data_in
);
  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // the access timer is CNT_W bits wide and needs at least one cycle
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES >= (1 << sem_host_pkg::CNT_W)) begin : g_bad_access
    $error("ACCESS_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_GAP = 3'b010,
    ST_READ = 3'b011,
    ST_DONE = 3'b100
  } state_t;

  state_t state;
  sem_host_pkg::cmd_t cmd;
  logic [sem_host_pkg::INDEX_W-1:0] index;
  logic [sem_host_pkg::CNT_W-1:0] count;
  logic [sem_host_pkg::INDEX_W-1:0] init_index;
  logic timer_done;
  localparam logic [sem_host_pkg::INDEX_W-1:0] LAST_INDEX =
    sem_host_pkg::INDEX_W'(sem_host_pkg::FLAG_COUNT - 1);

  assign timer_done = (count == sem_host_pkg::CNT_W'(ACCESS_CYCLES - 1));
  assign req_ready = (state == ST_IDLE);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // the access timer wraps on its last cycle so the next phase starts from zero
  function automatic logic [sem_host_pkg::CNT_W-1:0] count_step(
    input logic [sem_host_pkg::CNT_W-1:0] value,
    input logic last
  );
    count_step = last ? '0 : value + 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a claim is always write-then-read, never read-then-write, so no
  // window opens between the test and the set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cmd <= sem_host_pkg::CMD_POLL;
      index <= '0;
      count <= '0;
      init_index <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          count <= '0;
          if (req_valid) begin
            cmd <= req.cmd;
            // init always walks from flag zero, whatever index came with it
            index <= (req.cmd == sem_host_pkg::CMD_INIT) ? '0 : req.flag_index;
            init_index <= '0;
            if (req.cmd == sem_host_pkg::CMD_POLL) begin
              state <= ST_READ;
            end else begin
              state <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          count <= count_step(count, timer_done);
          if (timer_done) begin
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          count <= '0;
          if (cmd == sem_host_pkg::CMD_CLAIM) begin
            state <= ST_READ;
          end else if (cmd == sem_host_pkg::CMD_INIT && init_index != LAST_INDEX) begin
            init_index <= init_index + 1'b1;
            index <= init_index + 1'b1;
            state <= ST_WRITE;
          end else begin
            state <= ST_DONE;
          end
        end
        ST_READ: begin
          count <= count_step(count, timer_done);
          if (timer_done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // results
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      granted <= 1'b0;
    end else if (state == ST_READ && timer_done) begin
      // zero on data bit 0 means this side holds the token
      granted <= ~data_in[0];
    end else if (state == ST_WRITE && cmd != sem_host_pkg::CMD_CLAIM) begin
      granted <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      init_done <= 1'b0;
    end else begin
      done <= (state == ST_DONE);
      if (state == ST_DONE && cmd == sem_host_pkg::CMD_INIT) begin
        init_done <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= '{semaphore_select_n: 1'b1, memory_select_n: 1'b1, output_enable_n: 1'b1,
                read_write: 1'b1, address: '0, data_out: '0, data_oe_n: 1'b1};
    end else begin
      pins.memory_select_n <= 1'b1;
      pins.address <= {{(sem_host_pkg::ADDR_W-sem_host_pkg::INDEX_W){1'b0}}, index};
      case (state)
        ST_WRITE: begin
          pins.semaphore_select_n <= 1'b0;
          // rw rises a cycle before select so the data outlives the write
          pins.read_write <= timer_done;
          pins.output_enable_n <= 1'b1;
          pins.data_oe_n <= 1'b0;
          // claim writes zero, release and init write one
          pins.data_out <= (cmd == sem_host_pkg::CMD_CLAIM) ? sem_host_pkg::DATA_ZERO
                                                           : sem_host_pkg::DATA_ONES;
        end
        ST_READ: begin
          // data_in is taken on the last read cycle, while the device still drives it
          pins.semaphore_select_n <= timer_done;
          pins.read_write <= 1'b1;
          pins.output_enable_n <= timer_done;
          pins.data_oe_n <= 1'b1;
          pins.data_out <= pins.data_out;
        end
        default: begin
          pins.semaphore_select_n <= 1'b1;
          pins.read_write <= 1'b1;
          pins.output_enable_n <= 1'b1;
          pins.data_oe_n <= 1'b1;
          pins.data_out <= pins.data_out;
        end
      endcase
    end
  end
  // ownership hand-over and ties are the device's
  // the host only sees their result on the read-back
endmodule
`default_nettype wire

// [logic/sem_host_pkg.sv]
package sem_host_pkg;
  // ---------------------------------------------------------------
  // pin timing and layout
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACCESS_TIME_NS = 55;
  localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYCLES = 1;
  localparam int FLAG_COUNT = 8;
  localparam int INDEX_W = 3;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 13;
  localparam int CNT_W = 4;
  localparam logic [DATA_W-1:0] DATA_ONES = 8'hff;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // commands accepted on the host side
  typedef enum logic [1:0] {
    CMD_CLAIM = 2'b00,
    CMD_RELEASE = 2'b01,
    CMD_POLL = 2'b10,
    CMD_INIT = 2'b11
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic [INDEX_W-1:0] flag_index;
  } req_t;

  // port pins toward the dual-port device
  typedef struct packed {
    logic semaphore_select_n;
    logic memory_select_n;
    logic output_enable_n;
    logic read_write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] data_out;
    logic data_oe_n;
  } pins_t;
endpackage

// [verification/sem_host_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module sem_host_checker #(
  parameter int ACCESS_CYCLES = 3
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire sem_host_pkg::req_t req,
  input wire logic done,
  input wire logic granted,
  input wire logic init_done,
  input wire sem_host_pkg::pins_t pins,
  input wire logic [sem_host_pkg::DATA_W-1:0] data_in
);
  localparam int CLAIM_LAT = 2 * ACCESS_CYCLES + 3;
  localparam int REL_LAT = ACCESS_CYCLES + 3;
  localparam int INIT_LAT = 8 * (ACCESS_CYCLES + 1) + 2;
  logic take, sel, rd, wr, cl, rl, il;
  assign take = req_valid && req_ready;
  assign sel = !pins.semaphore_select_n;
  assign rd = sel && !pins.output_enable_n;
  assign wr = sel && !pins.read_write;
  assign cl = take && req.cmd == sem_host_pkg::CMD_CLAIM;
  assign rl = take && req.cmd == sem_host_pkg::CMD_RELEASE;
  assign il = take && req.cmd == sem_host_pkg::CMD_INIT;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  mem_idle_a: assert property (pins.memory_select_n) else $error("memory select");
  read_pins_a: assert property (rd |-> pins.read_write && pins.data_oe_n) else $error("read");
  write_drive_a: assert property (wr |-> !pins.data_oe_n) else $error("write");
  index_hold_a: assert property (sel && $past(sel) |-> $stable(pins.address[2:0]))
    else $error("index moved");
  poll_drop_a: assert property (rd |-> ##[1:8] !rd) else $error("read held");
  claim_order_a: assert property (cl |-> ##[1:4] (wr && !pins.data_out[0]) ##[1:8] rd)
    else $error("claim order");
  claim_time_a: assert property (cl |-> ##CLAIM_LAT done) else $error("claim time");
  release_one_a: assert property (rl |-> ##[1:4] (wr && pins.data_out[0]))
    else $error("release write");
  release_time_a: assert property (rl |-> ##REL_LAT (done && !granted)) else $error("rel");
  init_time_a: assert property (il |-> ##INIT_LAT done ##1 init_done) else $error("init");
  cover property (cl ##[1:20] granted);
  cover property (rl ##[1:20] done);
  cover property (il ##[1:40] init_done);
endmodule
`default_nettype wire

// [verification/sem_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module sem_dev (
  input wire sem_host_pkg::pins_t pins,
  input wire logic [7:0] far_req_n,
  output logic [7:0] data_in
);
  // stuck requests at power-up so a missing init shows up
  logic [7:0] near = 8'h00;
  logic [7:0] own_near = 8'h00;
  logic [7:0] own_far = 8'h00;
  logic [7:0] q = 8'h00;
  logic rd;
  assign rd = pins.memory_select_n && !pins.semaphore_select_n && !pins.output_enable_n
    && pins.read_write;
  always @(pins) if (!pins.semaphore_select_n && !pins.read_write)
    near[pins.address[2:0]] = pins.data_out[0];
  always @(near or far_req_n) for (int i = 0; i < 8; i++) begin
    if (near[i] && own_near[i]) own_near[i] = 1'b0;
    if (far_req_n[i] && own_far[i]) own_far[i] = 1'b0;
    if (!own_near[i] && !own_far[i]) begin
      if (!near[i]) own_near[i] = 1'b1;
      else if (!far_req_n[i]) own_far[i] = 1'b1;
    end
  end
  always @(posedge rd) q = {8{!own_near[pins.address[2:0]]}};
  // released bus shows inverted junk, never the old value; flags gate nothing
  assign data_in = rd ? q : ~q;
endmodule
`default_nettype wire

// [verification/sem_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sem_host_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  sem_host_pkg::req_t req = '0;
  logic req_ready, done, granted, init_done;
  sem_host_pkg::pins_t pins;
  logic [7:0] data_in;
  logic [7:0] far_req_n = 8'hff;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 mclk = ~mclk;
  sem_host #(.ACCESS_CYCLES(2)) sem_host_inst (.mclk(mclk), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
    .granted(granted), .init_done(init_done), .pins(pins), .data_in(data_in));
  sem_dev sem_dev_inst (.pins(pins), .far_req_n(far_req_n), .data_in(data_in));
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input sem_host_pkg::cmd_t c, input logic [2:0] i);
    int k;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= {c, i};
    do @(negedge mclk); while (!req_ready);
    @(posedge mclk);
    req_valid <= 1'b0;
    for (k = 0; k < 60 && done !== 1'b1; k++) @(negedge mclk);
    check(k < 60, 1'b1);
  endtask
  task automatic t_each;
    for (int i = 0; i < 8; i++) begin
      run(sem_host_pkg::CMD_CLAIM, i[2:0]);
      check(granted, 1'b1);
      check(sem_dev_inst.own_far, 8'h00);
      run(sem_host_pkg::CMD_RELEASE, i[2:0]);
      check(sem_dev_inst.own_near, 8'h00);
    end
  endtask
  task automatic t_lock;
    @(posedge mclk);
    far_req_n[2] <= 1'b0;
    run(sem_host_pkg::CMD_CLAIM, 3'h2);
    check(granted, 1'b0);
    @(posedge mclk);
    far_req_n[2] <= 1'b1;
    run(sem_host_pkg::CMD_POLL, 3'h2);
    check(granted, 1'b1);
    run(sem_host_pkg::CMD_RELEASE, 3'h2);
  endtask
  task automatic t_pass;
    run(sem_host_pkg::CMD_CLAIM, 3'h3);
    @(posedge mclk);
    far_req_n[3] <= 1'b0;
    run(sem_host_pkg::CMD_RELEASE, 3'h3);
    check(sem_dev_inst.own_far, 8'h08);
    run(sem_host_pkg::CMD_POLL, 3'h3);
    check(granted, 1'b0);
    @(posedge mclk);
    far_req_n[3] <= 1'b1;
  endtask
  task automatic t_init;
    // a nonzero index proves init still walks every flag from zero
    run(sem_host_pkg::CMD_INIT, 3'h5);
    check(init_done, 1'b1);
    check(sem_dev_inst.near, 8'hff);
  endtask
  task automatic t_reset;
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    check({granted, init_done, done, pins.semaphore_select_n, pins.data_oe_n}, 8'h03);
    repeat (3) @(posedge mclk);
    run(sem_host_pkg::CMD_CLAIM, 3'h1);
    check(granted, 1'b1);
    run(sem_host_pkg::CMD_RELEASE, 3'h1);
  endtask
  // the bound only cuts a hang; the full run needs a few hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_init;
    t_each;
    t_lock;
    t_pass;
    t_reset;
    stop_test;
  end
endmodule
bind sem_host sem_host_checker #(.ACCESS_CYCLES(ACCESS_CYCLES)) sem_host_checker_inst (
  .mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .done(done), .granted(granted), .init_done(init_done), .pins(pins),
  .data_in(data_in));
`default_nettype wire
